/* logic/dcfm_map.svh */
// Offsets, field positions, reset values and counts of the FIFO mailbox.
`ifndef DCFM_MAP_SVH
`define DCFM_MAP_SVH

`define DCFM_DATA_W      36
`define DCFM_DEPTH       512
`define DCFM_ADDR_W      9
`define DCFM_PTR_W       10
`define DCFM_DEPTH_CNT   10'h200
`define DCFM_OFS_W       9
`define DCFM_NE_RST      9'h008
`define DCFM_NF_RST      9'h008
`define DCFM_SER_W       18
`define DCFM_SER_LAST    5'h11
`define DCFM_PINA_W      43
`define DCFM_PINB_W      41
`define DCFM_EV_W        4

`define DCFM_REG_CTRL    8'h00
`define DCFM_REG_NE_OFS  8'h04
`define DCFM_REG_NF_OFS  8'h08
`define DCFM_REG_STATUS  8'h0c
`define DCFM_REG_INT_ST  8'h10
`define DCFM_REG_INT_MSK 8'h14

`define DCFM_CTRL_SER    0
`define DCFM_CTRL_PAR    1
`define DCFM_CTRL_RTX    2
`define DCFM_CTRL_REWIND 3

`define DCFM_EV_FULL     0
`define DCFM_EV_EMPTY    1
`define DCFM_EV_MAIL_B   2
`define DCFM_EV_MAIL_A   3

`define DCFM_RESP_OKAY   2'h0
`define DCFM_RESP_SLVERR 2'h2

`endif

/* logic/dcfm_pkg.sv */
// Types shared by the FIFO mailbox design files.
package dcfm_pkg;
`include "dcfm_map.svh"

    typedef struct packed {
        logic                    serData;
        logic                    serEnN;
        logic                    write;
        logic                    mail;
        logic                    qual;
        logic                    selN;
        logic                    clk;
        logic [`DCFM_DATA_W-1:0] data;
    } dcfm_pins_a_t;

    typedef struct packed {
        logic                    write;
        logic                    mail;
        logic                    qual;
        logic                    selN;
        logic                    clk;
        logic [`DCFM_DATA_W-1:0] data;
    } dcfm_pins_b_t;

    typedef struct packed {
        logic        awGot;
        logic [7:0]  awAddr;
        logic        wGot;
        logic [31:0] wData;
        logic [3:0]  wStrb;
        logic        awRdy;
        logic        wRdy;
        logic        bValid;
        logic [1:0]  bResp;
        logic        arRdy;
        logic        rValid;
        logic [31:0] rData;
        logic [1:0]  rResp;
    } dcfm_axi_t;

    typedef struct packed {
        dcfm_axi_t               axi;
        logic                    aClkPrev;
        logic                    bClkPrev;
        logic [`DCFM_PTR_W-1:0]  wrPtr;
        logic [`DCFM_PTR_W-1:0]  rdPtr;
        logic [`DCFM_PTR_W-1:0]  markPtr;
        logic                    rtxMode;
        logic [`DCFM_OFS_W-1:0]  neOfs;
        logic [`DCFM_OFS_W-1:0]  nfOfs;
        logic                    serMode;
        logic                    parLoad;
        logic [`DCFM_SER_W-1:0]  serShift;
        logic [4:0]              serCnt;
        logic [`DCFM_DATA_W-1:0] mailAB;
        logic [`DCFM_DATA_W-1:0] mailBA;
        logic                    mailToB;
        logic                    mailToA;
        logic [1:0]              wrRdySync;
        logic [1:0]              nfSync;
        logic [1:0]              rdRdySync;
        logic [1:0]              neSync;
        logic                    fullQ;
        logic                    emptyQ;
        logic [`DCFM_DATA_W-1:0] aOut;
        logic                    aOeN;
        logic [`DCFM_DATA_W-1:0] bOut;
        logic                    bOeN;
        logic [`DCFM_EV_W-1:0]   intStat;
        logic [`DCFM_EV_W-1:0]   intMask;
        logic                    irq;
    } dcfm_state_t;

endpackage : dcfm_pkg

/* logic/dcfm_sync.sv */
// Two-flop synchroniser for a group of pins entering the ref_clk domain.
`timescale 1ns/10ps
module dcfm_sync #(
    parameter int W = 1
) (
    input  wire logic         ref_clk,
    input  wire logic         nrst,
    input  wire logic [W-1:0] asyncIn,
    output      logic [W-1:0] syncOut
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } dcfm_sync_st_t;

    dcfm_sync_st_t q;
    dcfm_sync_st_t d;

    // The first stage feeds only the second, so metastability cannot spread.
    always_comb begin
        d    = q;
        d.s1 = asyncIn;
        d.s2 = q.s1;
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign syncOut = q.s2;
endmodule : dcfm_sync

/* logic/dcfm_top.sv */
// FIFO from side A to side B with two mailboxes and an AXI4-Lite register set.
//
// Summary of operation
// RQ1: Transfers only on qualified rising side clock edges.
// RQ2: Side clocks independent; same-instant transfers both taken.
// RQ3: Ordered array, 36 bits by 512 words.
// RQ4: Each side has a 36-bit two-way bus.
// RQ5: A flags shift on side A edges.
// RQ6: B flags shift on side B edges.
// RQ7: Near-empty low when count at most offset.
// RQ8: Near-full low when free space at most offset. In retransmit mode the code takes space from the read pointer, not the mark.
// RQ9: Offsets load from side A bus or serially.
// RQ10: Two mailboxes, A to B and B to A.
// RQ11: Each mailbox flags new mail to receiver.
// RQ12: Retransmit lets side B reread words.
// RQ13: Dedicated full and empty flags.
// RQ14: Parallel width use and depth chaining possible.
// RQ15: Select low to transfer; high floats outputs.
// RQ16: Qualify high on edge allows transfer.
// RQ17: Mail choice high picks mailbox, low array.
// RQ18: Write-ready low when full; writes ignored.
// RQ19: Read-ready high only with word; else ignored.
//
// Implementation choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module dcfm_top
    import dcfm_pkg::*;
(
    input  wire logic                    ref_clk,
    input  wire logic                    nrst,
    input  wire logic [7:0]              s_axi_awaddr,
    input  wire logic                    s_axi_awvalid,
    output      logic                    s_axi_awready,
    input  wire logic [31:0]             s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output      logic                    s_axi_wready,
    output      logic [1:0]              s_axi_bresp,
    output      logic                    s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    input  wire logic [7:0]              s_axi_araddr,
    input  wire logic                    s_axi_arvalid,
    output      logic                    s_axi_arready,
    output      logic [31:0]             s_axi_rdata,
    output      logic [1:0]              s_axi_rresp,
    output      logic                    s_axi_rvalid,
    input  wire logic                    s_axi_rready,
    input  wire logic                    sideAClock,
    input  wire logic                    sideASelectN,
    input  wire logic                    sideAQualify,
    input  wire logic                    sideAMailChoice,
    input  wire logic                    sideAWriteSel,
    input  wire logic [`DCFM_DATA_W-1:0] sideABusIn,
    output      logic [`DCFM_DATA_W-1:0] sideABusOut,
    output      logic                    sideABusOeN,
    input  wire logic                    serialEnableN,
    input  wire logic                    serialData,
    input  wire logic                    sideBClock,
    input  wire logic                    sideBSelectN,
    input  wire logic                    sideBQualify,
    input  wire logic                    sideBMailChoice,
    input  wire logic                    sideBWriteSel,
    input  wire logic [`DCFM_DATA_W-1:0] sideBBusIn,
    output      logic [`DCFM_DATA_W-1:0] sideBBusOut,
    output      logic                    sideBBusOeN,
    output      logic                    writeSpaceFlag,
    output      logic                    nearFullFlagN,
    output      logic                    readReadyFlag,
    output      logic                    nearEmptyFlagN,
    output      logic                    fifoFullFlag,
    output      logic                    fifoEmptyFlag,
    output      logic                    mailToBFlag,
    output      logic                    mailToAFlag,
    output      logic                    irq
);
    dcfm_state_t             q;
    dcfm_state_t             d;
    logic [`DCFM_PINA_W-1:0] aSyncOut;
    logic [`DCFM_PINB_W-1:0] bSyncOut;
    dcfm_pins_a_t            pa;
    dcfm_pins_b_t            pb;
    logic [`DCFM_DATA_W-1:0] mem [0:`DCFM_DEPTH-1];
    logic                    memWe;
    logic [`DCFM_ADDR_W-1:0] memWaddr;
    logic [`DCFM_DATA_W-1:0] memWdata;

    // Pins come from other clocks, so every one passes two flops first.
    dcfm_sync #(.W(`DCFM_PINA_W)) syncA (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .asyncIn ({serialData, serialEnableN, sideAWriteSel,
                   sideAMailChoice, sideAQualify, sideASelectN,
                   sideAClock, sideABusIn}),
        .syncOut (aSyncOut)
    );

    dcfm_sync #(.W(`DCFM_PINB_W)) syncB (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .asyncIn ({sideBWriteSel, sideBMailChoice, sideBQualify,
                   sideBSelectN, sideBClock, sideBBusIn}),
        .syncOut (bSyncOut)
    );

    assign pa = dcfm_pins_a_t'(aSyncOut);
    assign pb = dcfm_pins_b_t'(bSyncOut);

    always_comb begin
        logic                   aEdge;
        logic                   bEdge;
        logic                   aGo;
        logic                   bGo;
        logic [`DCFM_PTR_W-1:0] count;
        logic [`DCFM_PTR_W-1:0] held;
        logic [`DCFM_PTR_W-1:0] space;
        logic                   fullRaw;
        logic                   emptyRaw;
        logic                   neLow;
        logic                   nfLow;
        logic [`DCFM_EV_W-1:0]  ev;
        logic [`DCFM_EV_W-1:0]  w1c;
        logic [3:0]             wv;
        logic [`DCFM_OFS_W-1:0] wm;
        logic [`DCFM_OFS_W-1:0] wo;
        logic [31:0]            rv;
        aEdge    = 1'b0;
        bEdge    = 1'b0;
        aGo      = 1'b0;
        bGo      = 1'b0;
        ev       = '0;
        w1c      = '0;
        wv       = q.axi.wStrb[0] ? q.axi.wData[3:0]
                 : {1'b0, q.rtxMode, q.parLoad, q.serMode};
        wm       = {q.axi.wStrb[1], {8{q.axi.wStrb[0]}}};
        wo       = q.axi.wData[`DCFM_OFS_W-1:0] & wm;
        rv       = '0;
        d        = q;
        memWe    = 1'b0;
        memWaddr = q.wrPtr[`DCFM_ADDR_W-1:0];
        memWdata = pa.data;

        // In retransmit mode the marked word still counts as stored.
        count    = q.wrPtr - q.rdPtr;
        held     = q.rtxMode ? (q.wrPtr - q.markPtr) : count;
        space    = `DCFM_DEPTH_CNT - count;
        fullRaw  = (held == `DCFM_DEPTH_CNT); // RQ13
        emptyRaw = (q.wrPtr == q.rdPtr); // RQ13
        neLow    = (count <= {1'b0, q.neOfs}); // RQ7
        nfLow    = (space <= {1'b0, q.nfOfs}); // RQ8

        // Each side keeps its own edge detector, so two edges in one cycle
        // are both served.
        aEdge      = pa.clk & ~q.aClkPrev; // RQ2
        bEdge      = pb.clk & ~q.bClkPrev; // RQ2
        d.aClkPrev = pa.clk;
        d.bClkPrev = pb.clk;
        aGo        = aEdge & ~pa.selN & pa.qual; // RQ1 RQ15 RQ16
        bGo        = bEdge & ~pb.selN & pb.qual; // RQ1 RQ15 RQ16

        if (aEdge) begin
            d.aOeN      = pa.selN | pa.write; // RQ15 RQ4
            d.wrRdySync = {q.wrRdySync[0], ~fullRaw}; // RQ5
            d.nfSync    = {q.nfSync[0], ~nfLow}; // RQ5
        end
        if (bEdge) begin
            d.bOeN      = pb.selN | pb.write; // RQ15 RQ4
            d.rdRdySync = {q.rdRdySync[0], ~emptyRaw}; // RQ6
            d.neSync    = {q.neSync[0], ~neLow}; // RQ6
        end

        // Side A reads: only the B to A mailbox has data for it.
        if (aGo && !pa.write) begin
            if (pa.mail) begin // RQ17
                d.aOut    = q.mailBA;
                d.mailToA = 1'b0;
            end else begin
                d.aOut = '0;
            end
        end
        // Side B reads.
        if (bGo && !pb.write) begin
            if (pb.mail) begin // RQ17
                d.bOut    = q.mailAB;
                d.mailToB = 1'b0;
            end else if (q.rdRdySync[1] && !emptyRaw) begin // RQ19
                d.bOut  = mem[q.rdPtr[`DCFM_ADDR_W-1:0]]; // RQ3
                d.rdPtr = q.rdPtr + 1'b1;
            end
        end

        // Side A writes; a pending parallel load takes the first non-mail word.
        if (aGo && pa.write) begin
            if (pa.mail) begin // RQ17
                d.mailAB  = pa.data; // RQ10
                d.mailToB = 1'b1; // RQ11
                ev[`DCFM_EV_MAIL_B] = 1'b1;
            end else if (q.parLoad) begin
                d.neOfs   = pa.data[`DCFM_OFS_W-1:0]; // RQ9
                d.nfOfs   = pa.data[2*`DCFM_OFS_W-1:`DCFM_OFS_W]; // RQ9
                d.parLoad = 1'b0;
            end else if (q.wrRdySync[1] && !fullRaw) begin // RQ18
                memWe   = 1'b1; // RQ3
                d.wrPtr = q.wrPtr + 1'b1;
            end
        end
        // Side B writes go only to the B to A mailbox.
        if (bGo && pb.write && pb.mail) begin // RQ17
            d.mailBA  = pb.data; // RQ10
            d.mailToA = 1'b1; // RQ11
            ev[`DCFM_EV_MAIL_A] = 1'b1;
        end

        // Serial offsets arrive near-full MSB first, near-empty LSB last.
        if (aEdge && q.serMode && !pa.serEnN) begin
            d.serShift = {q.serShift[`DCFM_SER_W-2:0], pa.serData};
            if (q.serCnt == `DCFM_SER_LAST) begin
                d.neOfs  = d.serShift[`DCFM_OFS_W-1:0]; // RQ9
                d.nfOfs  = d.serShift[`DCFM_SER_W-1:`DCFM_OFS_W]; // RQ9
                d.serCnt = '0;
            end else begin
                d.serCnt = q.serCnt + 1'b1;
            end
        end

        // Full and empty go out as plain levels so that cascaded or
        // side-by-side parts can combine them outside.
        d.fullQ  = fullRaw; // RQ14
        d.emptyQ = emptyRaw; // RQ14
        ev[`DCFM_EV_FULL]  = fullRaw & ~q.fullQ;
        ev[`DCFM_EV_EMPTY] = emptyRaw & ~q.emptyQ;

        // AXI4-Lite response handshakes and write address and data capture.
        if (q.axi.bValid && s_axi_bready) begin
            d.axi.bValid = 1'b0;
        end
        if (q.axi.rValid && s_axi_rready) begin
            d.axi.rValid = 1'b0;
        end
        if (q.axi.awRdy && s_axi_awvalid) begin
            d.axi.awGot  = 1'b1;
            d.axi.awAddr = s_axi_awaddr;
        end
        if (q.axi.wRdy && s_axi_wvalid) begin
            d.axi.wGot  = 1'b1;
            d.axi.wData = s_axi_wdata;
            d.axi.wStrb = s_axi_wstrb;
        end

        // Register write, once both address and data are held.
        if (q.axi.awGot && q.axi.wGot && !q.axi.bValid) begin
            d.axi.awGot  = 1'b0;
            d.axi.wGot   = 1'b0;
            d.axi.bValid = 1'b1;
            d.axi.bResp  = `DCFM_RESP_OKAY;
            case ({q.axi.awAddr[7:2], 2'h0})
                `DCFM_REG_CTRL: begin
                    d.serMode = wv[`DCFM_CTRL_SER];
                    d.parLoad = wv[`DCFM_CTRL_PAR];
                    d.rtxMode = wv[`DCFM_CTRL_RTX]; // RQ12
                    if (wv[`DCFM_CTRL_RTX] && !q.rtxMode) begin
                        d.markPtr = d.rdPtr; // RQ12
                    end
                    // Rewinding wins over a side B read in the same cycle.
                    if (wv[`DCFM_CTRL_REWIND] && q.rtxMode) begin
                        d.rdPtr = q.markPtr; // RQ12
                    end
                end
                `DCFM_REG_NE_OFS: d.neOfs = wo | (q.neOfs & ~wm);
                `DCFM_REG_NF_OFS: d.nfOfs = wo | (q.nfOfs & ~wm);
                `DCFM_REG_STATUS: ;
                `DCFM_REG_INT_ST: begin
                    w1c = q.axi.wStrb[0] ? q.axi.wData[`DCFM_EV_W-1:0] : '0;
                end
                `DCFM_REG_INT_MSK: begin
                    if (q.axi.wStrb[0]) begin
                        d.intMask = q.axi.wData[`DCFM_EV_W-1:0];
                    end
                end
                default: d.axi.bResp = `DCFM_RESP_SLVERR;
            endcase
        end

        // Register read.
        if (q.axi.arRdy && s_axi_arvalid) begin
            d.axi.rValid = 1'b1;
            d.axi.rResp  = `DCFM_RESP_OKAY;
            case ({s_axi_araddr[7:2], 2'h0})
                `DCFM_REG_CTRL: rv = {29'h0, q.rtxMode, q.parLoad, q.serMode};
                `DCFM_REG_NE_OFS: rv = {23'h0, q.neOfs};
                `DCFM_REG_NF_OFS: rv = {23'h0, q.nfOfs};
                `DCFM_REG_STATUS: begin
                    rv = {6'h0, count, 8'h0, q.mailToA, q.mailToB,
                          q.neSync[1], q.rdRdySync[1], q.nfSync[1],
                          q.wrRdySync[1], q.emptyQ, q.fullQ};
                end
                `DCFM_REG_INT_ST: rv = {28'h0, q.intStat};
                `DCFM_REG_INT_MSK: rv = {28'h0, q.intMask};
                default: d.axi.rResp = `DCFM_RESP_SLVERR;
            endcase
            d.axi.rData = rv;
        end

        d.axi.awRdy = ~d.axi.awGot;
        d.axi.wRdy  = ~d.axi.wGot;
        d.axi.arRdy = ~d.axi.rValid;

        // A new event outranks a software clear of the same bit.
        d.intStat = (q.intStat & ~w1c) | ev;
        d.irq     = |(d.intStat & d.intMask);
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            q           <= '0;
            q.neOfs     <= `DCFM_NE_RST;
            q.nfOfs     <= `DCFM_NF_RST;
            q.emptyQ    <= 1'b1;
            q.aOeN      <= 1'b1;
            q.bOeN      <= 1'b1;
            q.axi.awRdy <= 1'b1;
            q.axi.wRdy  <= 1'b1;
            q.axi.arRdy <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // The array has no reset; stale words are never read past the pointers.
    always_ff @(posedge ref_clk) begin
        if (memWe) begin
            mem[memWaddr] <= memWdata; // RQ3
        end
    end

    assign s_axi_awready  = q.axi.awRdy;
    assign s_axi_wready   = q.axi.wRdy;
    assign s_axi_bresp    = q.axi.bResp;
    assign s_axi_bvalid   = q.axi.bValid;
    assign s_axi_arready  = q.axi.arRdy;
    assign s_axi_rdata    = q.axi.rData;
    assign s_axi_rresp    = q.axi.rResp;
    assign s_axi_rvalid   = q.axi.rValid;
    assign sideABusOut    = q.aOut;
    assign sideABusOeN    = q.aOeN;
    assign sideBBusOut    = q.bOut;
    assign sideBBusOeN    = q.bOeN;
    assign writeSpaceFlag = q.wrRdySync[1];
    assign nearFullFlagN  = q.nfSync[1];
    assign readReadyFlag  = q.rdRdySync[1];
    assign nearEmptyFlagN = q.neSync[1];
    assign fifoFullFlag   = q.fullQ;
    assign fifoEmptyFlag  = q.emptyQ;
    assign mailToBFlag    = q.mailToB;
    assign mailToAFlag    = q.mailToA;
    assign irq            = q.irq;
endmodule : dcfm_top

/* verif/dcfm_checker.sv */
// Assertions on the side ports and flags of the FIFO mailbox.
`timescale 1ns/10ps
module dcfm_checker
    import dcfm_pkg::*;
(
    input wire logic        ref_clk,
    input wire logic        nrst,
    input wire logic        sideAClock,
    input wire logic        sideBClock,
    input wire logic        sideBSelectN,
    input wire logic [35:0] sideBBusOut,
    input wire logic        sideBBusOeN,
    input wire logic        writeSpaceFlag,
    input wire logic        nearFullFlagN,
    input wire logic        readReadyFlag,
    input wire logic        nearEmptyFlagN,
    input wire logic        fifoFullFlag,
    input wire logic        fifoEmptyFlag,
    input wire logic        mailToBFlag
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // Cycles since a side clock pin rose, for edge-bound outputs.
    logic [3:0] aSince_q;
    logic [3:0] bSince_q;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            aSince_q <= 4'hf;
            bSince_q <= 4'hf;
        end else begin
            aSince_q <= $rose(sideAClock) ? 4'h0 : aSince_q + 4'(~&aSince_q);
            bSince_q <= $rose(sideBClock) ? 4'h0 : bSince_q + 4'(~&bSince_q);
        end
    end
    sequence sFullRise;
        $rose(fifoFullFlag);
    endsequence
    flags_excl_a: assert property (!(fifoFullFlag && fifoEmptyFlag))
        else $error("full and empty flags high together");
    full_blocks_a: assert property (sFullRise
        |-> ##[1:30] !writeSpaceFlag) else $error("space flag high when full");
    ready_word_a: assert property ($rose(readReadyFlag)
        |-> !fifoEmptyFlag) else $error("read ready rose while empty");
    aflag_edge_a: assert property (
        $changed({writeSpaceFlag, nearFullFlagN})
        |-> aSince_q inside {[4'h1:4'h5]}) else $error("A flag moved off edge");
    bflag_edge_a: assert property (
        $changed({readReadyFlag, nearEmptyFlagN})
        |-> bSince_q inside {[4'h1:4'h5]}) else $error("B flag moved off edge");
    bout_edge_a: assert property ($changed(sideBBusOut)
        |-> bSince_q inside {[4'h1:4'h5]}) else $error("B data moved off edge");
    b_drive_a: assert property ($fell(sideBBusOeN)
        |-> bSince_q < 4'h6 && !$past(sideBSelectN, 3))
        else $error("B bus driven unselected");
    mail_new_a: assert property ($rose(mailToBFlag)
        |-> aSince_q inside {[4'h1:4'h5]}) else $error("mail flag off A edge");
endmodule : dcfm_checker

/* verif/dcfm_side_host.sv */
// Host model for both side ports: free-running side clocks and transfers.
`timescale 1ns/10ps
module dcfm_side_host
    import dcfm_pkg::*;
(
    input  wire logic         ref_clk,
    input  wire logic [35:0]  aOut,
    input  wire logic [35:0]  bOut,
    output      dcfm_pins_a_t pa,
    output      dcfm_pins_b_t pb
);
    logic [2:0] aCnt = 3'h0;
    logic [3:0] bCnt = 4'h0;
    initial begin
        pa = '{serEnN: 1'b1, selN: 1'b1, default: '0};
        pb = '{selN: 1'b1, default: '0};
    end
    // Side clock periods of 8 and 10 cycles suit the pin syncs.
    always @(posedge ref_clk) begin
        aCnt <= aCnt + 3'h1;
        bCnt <= (bCnt == 4'h9) ? 4'h0 : bCnt + 4'h1;
        pa.clk <= aCnt[2];
        pb.clk <= bCnt > 4'h4;
    end
    // Controls are set at a falling side edge and held past the next rise.
    task automatic op(input bit b, input bit w, input bit m,
                      input logic [35:0] d, output logic [35:0] q);
        @(posedge ref_clk);
        while ((b ? bCnt : {1'b0, aCnt}) != 4'h0) @(posedge ref_clk);
        if (b) begin
            {pb.write, pb.mail, pb.qual, pb.selN} <= {w, m, 2'b10};
            pb.data <= d;
        end else begin
            {pa.write, pa.mail, pa.qual, pa.selN} <= {w, m, 2'b10};
            pa.data <= d;
        end
        repeat (b ? 11 : 9) @(posedge ref_clk);
        q = b ? bOut : aOut;
        if (b) {pb.qual, pb.selN, pb.data} <= {2'b01, ~d};
        else {pa.qual, pa.selN, pa.data} <= {2'b01, ~d};
    endtask : op
endmodule : dcfm_side_host

/* verif/dcfm_tb_top.sv */
// Self-checking bench for the FIFO mailbox block.
`timescale 1ns/10ps
`include "dcfm_map.svh"
module dcfm_tb_top
    import dcfm_pkg::*;
;
    logic         ref_clk = 1'b0, nrst = 1'b0;
    logic [7:0]   s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0]  s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]   s_axi_wstrb = 4'hf;
    logic         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic         s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic         s_axi_rready = 1'b0;
    logic         s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic         s_axi_arready, s_axi_rvalid;
    logic [1:0]   s_axi_bresp, s_axi_rresp;
    logic [35:0]  sideABusOut, sideBBusOut, q;
    logic         sideABusOeN, sideBBusOeN, writeSpaceFlag, nearFullFlagN;
    logic         readReadyFlag, nearEmptyFlagN, fifoFullFlag, fifoEmptyFlag;
    logic         mailToBFlag, mailToAFlag, irq;
    dcfm_pins_a_t pa;
    dcfm_pins_b_t pb;
    int           num_errors = 0, n_compared = 0;
    dcfm_top dut_u (
        .sideAClock(pa.clk), .sideASelectN(pa.selN), .sideAQualify(pa.qual),
        .sideAMailChoice(pa.mail), .sideAWriteSel(pa.write),
        .sideABusIn(pa.data), .serialEnableN(pa.serEnN),
        .serialData(pa.serData), .sideBClock(pb.clk), .sideBSelectN(pb.selN),
        .sideBQualify(pb.qual), .sideBMailChoice(pb.mail),
        .sideBWriteSel(pb.write), .sideBBusIn(pb.data), .*);
    dcfm_side_host host_u (.ref_clk, .aOut(sideABusOut), .bOut(sideBBusOut),
        .pa, .pb);
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic chk(input string n, input logic [35:0] e, s);
        n_compared++;
        if (s !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic chkb(input string n, input logic e, s);
        chk(n, {35'h0, e}, {35'h0, s});
    endtask : chkb
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        for (int i = 0; i < 50 && !s_axi_bvalid; i++) begin
            @(posedge ref_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
        chkb("bvalid", 1'b1, s_axi_bvalid);
        chk("bresp", {34'h0, `DCFM_RESP_OKAY}, {34'h0, s_axi_bresp});
    endtask : axw
    task automatic axr(input logic [7:0] a, input logic [31:0] e,
                       input logic [1:0] r);
        @(posedge ref_clk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'b11;
        for (int i = 0; i < 50 && !s_axi_rvalid; i++) begin
            @(posedge ref_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
        chkb("rvalid", 1'b1, s_axi_rvalid);
        chk("rdata", {4'h0, e}, {4'h0, s_axi_rdata});
        chk("rresp", {34'h0, r}, {34'h0, s_axi_rresp});
    endtask : axr
    function automatic logic [35:0] pat(input int i);
        return {4'(i + 5), 16'(i), 16'(~i)};
    endfunction : pat
    task automatic t_fill();
        axr(`DCFM_REG_NE_OFS, 32'(`DCFM_NE_RST), `DCFM_RESP_OKAY);
        axr(8'h40, 32'h0, `DCFM_RESP_SLVERR);
        axw(`DCFM_REG_INT_MSK, 32'h1);
        for (int i = 0; i < 60 && !writeSpaceFlag; i++) @(posedge ref_clk);
        for (int i = 0; i < 514; i++) host_u.op(0, 1, 0, pat(i), q);
        chkb("full", 1'b1, fifoFullFlag);
        chkb("space", 1'b0, writeSpaceFlag);
        chkb("nearFullN", 1'b0, nearFullFlagN);
        chkb("irq", 1'b1, irq);
        axw(`DCFM_REG_INT_ST, 32'h1);
        repeat (2) @(posedge ref_clk);
        chkb("irq", 1'b0, irq);
        $display("fill test done");
    endtask : t_fill
    task automatic t_drain();
        chkb("ready", 1'b1, readReadyFlag);
        chkb("nearEmptyN", 1'b1, nearEmptyFlagN);
        for (int i = 0; i < 512; i++) begin
            host_u.op(1, 0, 0, 36'h0, q);
            chk("word", pat(i), q);
        end
        repeat (2) host_u.op(1, 0, 0, 36'h0, q);
        chk("stale", pat(511), q);
        chkb("empty", 1'b1, fifoEmptyFlag);
        chkb("ready", 1'b0, readReadyFlag);
        chkb("nearEmptyN", 1'b0, nearEmptyFlagN);
        chkb("irq", 1'b0, irq);
        axr(`DCFM_REG_INT_ST, 32'h2, `DCFM_RESP_OKAY);
        $display("drain test done");
    endtask : t_drain
    task automatic t_mail();
        host_u.op(0, 1, 1, 36'h9_1234_5678, q);
        chkb("mailToB", 1'b1, mailToBFlag);
        host_u.op(1, 0, 1, 36'h0, q);
        chk("mailAB", 36'h9_1234_5678, q);
        chkb("mailToB", 1'b0, mailToBFlag);
        host_u.op(1, 1, 1, 36'h6_edcb_a987, q);
        chkb("mailToA", 1'b1, mailToAFlag);
        host_u.op(0, 0, 1, 36'h0, q);
        chk("mailBA", 36'h6_edcb_a987, q);
        chkb("mailToA", 1'b0, mailToAFlag);
        axw(`DCFM_REG_CTRL, 32'h2);
        host_u.op(0, 1, 0, 36'h1805, q);
        axr(`DCFM_REG_NE_OFS, 32'h5, `DCFM_RESP_OKAY);
        axr(`DCFM_REG_NF_OFS, 32'hc, `DCFM_RESP_OKAY);
        chkb("empty", 1'b1, fifoEmptyFlag);
        $display("mail test done");
    endtask : t_mail
    task automatic end_of_test();
        $display("compared %0d mismatched %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_of_test
    initial begin
        repeat (60000) @(posedge ref_clk);
        num_errors++;
        end_of_test();
    end
    initial begin
        repeat (20) @(posedge ref_clk);
        nrst <= 1'b1;
        t_fill();
        t_drain();
        t_mail();
        end_of_test();
    end
endmodule : dcfm_tb_top
bind dcfm_top dcfm_checker chk_u (.*);
